// *** design/isp_pkg.sv ***
package isp_pkg;
   // ==========================================================
   // Clocking of this controller and of the target
   localparam real CLK_PERIOD_NS = 5.0;
   localparam real DEV_CLK_MHZ = 16.0;
   localparam real DEV_FAST_MHZ = 12.0;
   localparam int DEV_SLOW_PHASE = 2;
   localparam int DEV_FAST_PHASE = 3;
   localparam int DEV_PHASE = (DEV_CLK_MHZ < DEV_FAST_MHZ) ?
      DEV_SLOW_PHASE : DEV_FAST_PHASE;
   // Each serial clock phase must exceed DEV_PHASE target cycles
   localparam real SCK_HALF_NS = (DEV_PHASE + 1) * 1000.0 / DEV_CLK_MHZ;
   localparam int SCK_HALF_CYC = int'($ceil(SCK_HALF_NS / CLK_PERIOD_NS));
   // Reset pulse of at least two target cycles
   localparam int RST_PULSE_DEV = 2;
   localparam real RST_PULSE_NS = RST_PULSE_DEV * 1000.0 / DEV_CLK_MHZ;
   localparam int RST_PULSE_CYC = int'($ceil(RST_PULSE_NS / CLK_PERIOD_NS));

   // ==========================================================
   // Long waits, in milliseconds as printed
   localparam real PWR_WAIT_MS = 20.0;
   localparam real FLASH_WAIT_MS = 4.5;
   localparam real EEPROM_WAIT_MS = 9.0;
   localparam int PWR_WAIT_CYC =
      int'($ceil(PWR_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int FLASH_WAIT_CYC =
      int'($ceil(FLASH_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int EEPROM_WAIT_CYC =
      int'($ceil(EEPROM_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));

   // ==========================================================
   // Instruction bytes
   localparam logic [7:0] INS_ENABLE = 8'hAC;
   localparam logic [7:0] ENABLE_KEY = 8'h53;
   localparam logic [7:0] ERASE_KEY = 8'h80;
   localparam logic [7:0] INS_POLL = 8'hF0;
   localparam logic [7:0] INS_LD_LO = 8'h40;
   localparam logic [7:0] INS_LD_HI = 8'h48;
   localparam logic [7:0] INS_WR_PAGE = 8'h4C;
   localparam logic [7:0] INS_LD_EE = 8'hC1;
   localparam logic [7:0] INS_WR_EE_PAGE = 8'hC2;
   localparam logic [7:0] INS_WR_EE = 8'hC0;
   localparam logic [7:0] INS_RD_LO = 8'h20;
   localparam logic [7:0] INS_RD_HI = 8'h28;
   localparam logic [7:0] INS_RD_EE = 8'hA0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam int FRAME_BITS = 32;
   localparam int ECHO_LSB = 8;
   localparam int BUSY_BIT = 0;
   localparam int WORD_BITS = 6;
   localparam int EE_PAGE_BITS = 2;
   localparam logic [2:0] MAX_TRIES = 3'h4;

   // Host commands
   typedef enum logic [3:0] {
      OP_ENABLE, OP_ERASE, OP_LD_FLASH_LO, OP_LD_FLASH_HI, OP_WR_FLASH_PAGE,
      OP_LD_EE_PAGE, OP_WR_EE_PAGE, OP_WR_EE_BYTE, OP_RD_FLASH_LO,
      OP_RD_FLASH_HI, OP_RD_EE, OP_POLL, OP_END
   } isp_op_type;
endpackage

// *** design/isp_prog.sv ***
// What this block does
// - Programming happens only with reset low; host drives SCK, MOSI.
// - Enable instruction first; nothing else is sent until accepted.
// - Each SCK phase lasts longer than 2 or 3 target cycles.
// - Reset and SCK held low at power-up; reset pulses last two cycles.
// - Wait 20 ms after power-up before the enable instruction.
// - Always send four bytes; on bad echo pulse reset, resend enable.
// - Flash page load sends one byte with six word address bits.
// - Low byte of each word is loaded before its high byte.
// - Page write with the full 16-bit address commits the buffer.
// - No serial access until a flash write has completed.
// - EEPROM byte write carries address and data, then waits.
// - EEPROM page load uses two address bits; commit uses upper bits.
// - Reset released high ends programming mode.
// - Busy poll bit 0 high means pending; wait until it reads 0.
// - Without polling wait 4.5 ms after flash, 9.0 ms after EEPROM.
module isp_prog #(
   parameter int unsigned PWR_WAIT = isp_pkg::PWR_WAIT_CYC,
   parameter int unsigned FLASH_WAIT = isp_pkg::FLASH_WAIT_CYC,
   parameter int unsigned EEPROM_WAIT = isp_pkg::EEPROM_WAIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire isp_pkg::isp_op_type cmd_op,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic poll_mode,
   output logic rsp_valid,
   output logic rsp_error,
   output logic [7:0] rsp_data,
   output logic isp_reset_pin,
   output logic isp_sck,
   output logic isp_mosi,
   input wire logic isp_miso
);
   import isp_pkg::*;

   typedef enum logic [3:0] {
      ST_PWR, ST_IDLE, ST_SHIFT, ST_RST_HI, ST_RST_LO, ST_WAIT, ST_POLL,
      ST_OFF
   } isp_main_type;

   typedef struct packed {
      isp_main_type st;
      logic pin_rst;
      logic enabled;
      logic [2:0] tries;
      logic [31:0] timer;
      isp_op_type op;
      logic lo_ok;
      logic [WORD_BITS-1:0] lo_addr;
      logic rsp_valid;
      logic rsp_error;
      logic [7:0] rsp_data;
      logic go;
      logic [FRAME_BITS-1:0] frame;
   } isp_prog_type;

   localparam logic [31:0] PWR_LAST = 32'(PWR_WAIT - 1);
   localparam logic [31:0] FLASH_LAST = 32'(FLASH_WAIT - 1);
   localparam logic [31:0] EEPROM_LAST = 32'(EEPROM_WAIT - 1);
   localparam logic [31:0] PULSE_LAST = 32'(RST_PULSE_CYC - 1);
   localparam logic [FRAME_BITS-1:0] ENABLE_FRAME =
      {INS_ENABLE, ENABLE_KEY, ZERO_BYTE, ZERO_BYTE};
   localparam logic [FRAME_BITS-1:0] POLL_FRAME =
      {INS_POLL, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE};

   isp_prog_type s;
   isp_prog_type next_s;
   logic sh_done;
   logic [FRAME_BITS-1:0] sh_rx;

   // ==========================================================
   // Four byte instruction for each command
   function automatic logic [FRAME_BITS-1:0] build(
      input isp_op_type op, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] word_lsb;
      logic [7:0] ee_lsb;
      word_lsb = {{(8-WORD_BITS){1'b0}}, a[WORD_BITS-1:0]};
      ee_lsb = {{(8-EE_PAGE_BITS){1'b0}}, a[EE_PAGE_BITS-1:0]};
      case (op)
         OP_ENABLE: build = ENABLE_FRAME;
         OP_ERASE: build = {INS_ENABLE, ERASE_KEY, ZERO_BYTE, ZERO_BYTE};
         OP_LD_FLASH_LO: build = {INS_LD_LO, ZERO_BYTE, word_lsb, d};
         OP_LD_FLASH_HI: build = {INS_LD_HI, ZERO_BYTE, word_lsb, d};
         OP_WR_FLASH_PAGE: build = {INS_WR_PAGE, a, ZERO_BYTE};
         OP_LD_EE_PAGE: build = {INS_LD_EE, ZERO_BYTE, ee_lsb, d};
         OP_WR_EE_PAGE: build = {INS_WR_EE_PAGE, a[15:8],
            a[7:EE_PAGE_BITS], {EE_PAGE_BITS{1'b0}}, ZERO_BYTE};
         OP_WR_EE_BYTE: build = {INS_WR_EE, a, d};
         OP_RD_FLASH_LO: build = {INS_RD_LO, a, ZERO_BYTE};
         OP_RD_FLASH_HI: build = {INS_RD_HI, a, ZERO_BYTE};
         OP_RD_EE: build = {INS_RD_EE, a, ZERO_BYTE};
         default: build = POLL_FRAME;
      endcase
   endfunction

   // Commands that start a self-timed write in the target
   function automatic logic is_write(input isp_op_type op);
      is_write = (op == OP_ERASE) || (op == OP_WR_FLASH_PAGE) ||
         (op == OP_WR_EE_PAGE) || (op == OP_WR_EE_BYTE);
   endfunction

   // ==========================================================
   // Session sequencer
   always_comb begin
      next_s = s;
      next_s.go = 1'b0;
      next_s.rsp_valid = 1'b0;
      next_s.rsp_error = 1'b0;
      case (s.st)
         ST_PWR: begin
            // Reset and SCK low through the power-up wait
            next_s.timer = s.timer + 32'h1;
            if (s.timer == PWR_LAST) begin
               next_s.timer = '0;
               next_s.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (cmd_valid) begin
               next_s.op = cmd_op;
               next_s.frame = build(cmd_op, cmd_addr, cmd_data);
               if (cmd_op == OP_END) begin
                  next_s.pin_rst = 1'b1;
                  next_s.enabled = 1'b0;
                  next_s.rsp_valid = 1'b1;
                  next_s.st = ST_OFF;
               end else if (cmd_op == OP_ENABLE) begin
                  next_s.tries = '0;
                  next_s.go = 1'b1;
                  next_s.st = ST_SHIFT;
               end else if (!s.enabled) begin
                  next_s.rsp_valid = 1'b1;
                  next_s.rsp_error = 1'b1;
               end else if (cmd_op == OP_LD_FLASH_HI && !(s.lo_ok &&
                  s.lo_addr == cmd_addr[WORD_BITS-1:0])) begin
                  next_s.rsp_valid = 1'b1;
                  next_s.rsp_error = 1'b1;
               end else begin
                  next_s.lo_ok = (cmd_op == OP_LD_FLASH_LO);
                  next_s.lo_addr = cmd_addr[WORD_BITS-1:0];
                  next_s.go = 1'b1;
                  next_s.st = ST_SHIFT;
               end
            end
         end
         ST_OFF: begin
            if (cmd_valid) begin
               if (cmd_op == OP_ENABLE) begin
                  // Pull reset low again and let it settle
                  next_s.pin_rst = 1'b0;
                  next_s.tries = '0;
                  next_s.op = cmd_op;
                  next_s.frame = ENABLE_FRAME;
                  next_s.timer = '0;
                  next_s.st = ST_RST_LO;
               end else begin
                  next_s.rsp_valid = 1'b1;
                  next_s.rsp_error = !(cmd_op == OP_END);
               end
            end
         end
         ST_SHIFT: begin
            if (sh_done) begin
               next_s.rsp_data = sh_rx[7:0];
               if (s.op == OP_ENABLE) begin
                  if (sh_rx[ECHO_LSB+7:ECHO_LSB] == ENABLE_KEY) begin
                     next_s.enabled = 1'b1;
                     next_s.rsp_valid = 1'b1;
                     next_s.st = ST_IDLE;
                  end else if (s.tries == MAX_TRIES - 3'h1) begin
                     next_s.rsp_valid = 1'b1;
                     next_s.rsp_error = 1'b1;
                     next_s.st = ST_IDLE;
                  end else begin
                     next_s.pin_rst = 1'b1;
                     next_s.tries = s.tries + 3'h1;
                     next_s.timer = '0;
                     next_s.st = ST_RST_HI;
                  end
               end else if (is_write(s.op)) begin
                  next_s.timer = (s.op == OP_WR_FLASH_PAGE) ?
                     FLASH_LAST : EEPROM_LAST;
                  if (poll_mode) begin
                     next_s.frame = POLL_FRAME;
                     next_s.go = 1'b1;
                     next_s.st = ST_POLL;
                  end else begin
                     next_s.st = ST_WAIT;
                  end
               end else begin
                  next_s.rsp_valid = 1'b1;
                  next_s.st = ST_IDLE;
               end
            end
         end
         ST_RST_HI: begin
            next_s.timer = s.timer + 32'h1;
            if (s.timer == PULSE_LAST) begin
               next_s.pin_rst = 1'b0;
               next_s.timer = '0;
               next_s.st = ST_RST_LO;
            end
         end
         ST_RST_LO: begin
            next_s.timer = s.timer + 32'h1;
            if (s.timer == PULSE_LAST) begin
               next_s.go = 1'b1;
               next_s.st = ST_SHIFT;
            end
         end
         ST_WAIT: begin
            // Port stays silent until the write time is over
            next_s.timer = s.timer - 32'h1;
            if (s.timer == '0) begin
               next_s.rsp_valid = 1'b1;
               next_s.st = ST_IDLE;
            end
         end
         ST_POLL: begin
            if (sh_done) begin
               if (!sh_rx[BUSY_BIT]) begin
                  next_s.rsp_valid = 1'b1;
                  next_s.st = ST_IDLE;
               end else begin
                  next_s.go = 1'b1;
               end
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Serial engine, four bytes MSB first
   isp_shift u_shift (
      .clk(clk),
      .rst(rst),
      .start(s.go),
      .frame(s.frame),
      .miso(isp_miso),
      .sck(isp_sck),
      .mosi(isp_mosi),
      .done(sh_done),
      .rx(sh_rx)
   );

   assign cmd_ready = (s.st == ST_IDLE) || (s.st == ST_OFF);
   assign rsp_valid = s.rsp_valid;
   assign rsp_error = s.rsp_error;
   assign rsp_data = s.rsp_data;
   assign isp_reset_pin = s.pin_rst;

   // ==========================================================
   // Checks
   rst_low_shift_a: assert property (
      @(posedge clk) disable iff (rst)
      (s.st == ST_SHIFT || s.st == ST_POLL) |-> !isp_reset_pin)
      else $error("reset pin high during a transfer");
   enable_first_a: assert property (
      @(posedge clk) disable iff (rst)
      s.go && s.frame != ENABLE_FRAME |-> s.enabled)
      else $error("instruction sent before enable");
   pwr_wait_a: assert property (
      @(posedge clk) disable iff (rst)
      $past(s.st) == ST_PWR && s.st != ST_PWR |-> $past(s.timer) == PWR_LAST)
      else $error("power-up wait cut short");
   echo_retry_a: assert property (
      @(posedge clk) disable iff (rst)
      s.st == ST_SHIFT && sh_done && s.op == OP_ENABLE &&
      sh_rx[ECHO_LSB+7:ECHO_LSB] != ENABLE_KEY && s.tries != MAX_TRIES-3'h1
      |=> isp_reset_pin [*8])
      else $error("bad echo without reset pulse");
   hi_after_lo_a: assert property (
      @(posedge clk) disable iff (rst)
      s.go && s.frame[31:24] == INS_LD_HI |-> $past(s.lo_ok))
      else $error("high byte loaded before low byte");
   write_quiet_a: assert property (
      @(posedge clk) disable iff (rst)
      s.st == ST_WAIT && s.timer != '0 |=> !s.go && !rsp_valid)
      else $error("port used during a write wait");
   end_release_a: assert property (
      @(posedge clk) disable iff (rst)
      cmd_valid && cmd_ready && cmd_op == OP_END && s.st == ST_IDLE
      |=> isp_reset_pin && rsp_valid && !rsp_error)
      else $error("end of session did not release reset");
   poll_busy_a: assert property (
      @(posedge clk) disable iff (rst)
      s.st == ST_POLL && sh_done && sh_rx[BUSY_BIT] |=> s.go && !rsp_valid)
      else $error("busy poll answered while pending");

   enable_ok_c: cover property (@(posedge clk) disable iff (rst)
      (s.st == ST_SHIFT && s.op == OP_ENABLE) ##1 s.enabled);
   retry_c: cover property (@(posedge clk) disable iff (rst)
      s.st == ST_RST_HI);
   wait_done_c: cover property (@(posedge clk) disable iff (rst)
      s.st == ST_WAIT && s.timer == '0);
   poll_done_c: cover property (@(posedge clk) disable iff (rst)
      s.st == ST_POLL && sh_done && !sh_rx[BUSY_BIT]);
endmodule

// *** design/isp_shift.sv ***
module isp_shift (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [isp_pkg::FRAME_BITS-1:0] frame,
   input wire logic miso,
   output logic sck,
   output logic mosi,
   output logic done,
   output logic [isp_pkg::FRAME_BITS-1:0] rx
);
   import isp_pkg::*;

   typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} isp_sh_type;
   typedef struct packed {
      isp_sh_type st;
      logic [7:0] cnt;
      logic [4:0] bit_i;
      logic [FRAME_BITS-1:0] sh;
      logic [FRAME_BITS-1:0] rx;
      logic sck;
      logic mosi;
      logic done;
      logic m1;
      logic m2;
   } isp_shift_type;

   localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYC - 1);
   localparam logic [4:0] BIT_LAST = 5'(FRAME_BITS - 1);

   isp_shift_type s;
   isp_shift_type next_s;

   // ==========================================================
   // Bit engine, MSB first, mode 0 timing
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.m1 = miso;
      next_s.m2 = s.m1;
      case (s.st)
         SH_IDLE: begin
            if (start) begin
               next_s.sh = frame;
               next_s.mosi = frame[FRAME_BITS-1];
               next_s.bit_i = '0;
               next_s.cnt = '0;
               next_s.st = SH_LOW;
            end
         end
         SH_LOW: begin
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == HALF_LAST) begin
               // Target samples MOSI on this rise; MISO settled on the fall
               next_s.sck = 1'b1;
               next_s.rx = {s.rx[FRAME_BITS-2:0], s.m2};
               next_s.cnt = '0;
               next_s.st = SH_HIGH;
            end
         end
         SH_HIGH: begin
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == HALF_LAST) begin
               next_s.sck = 1'b0;
               next_s.cnt = '0;
               if (s.bit_i == BIT_LAST) begin
                  next_s.done = 1'b1;
                  next_s.st = SH_IDLE;
               end else begin
                  // New bit set up at the fall, a half period before the rise
                  next_s.sh = {s.sh[FRAME_BITS-2:0], 1'b0};
                  next_s.mosi = s.sh[FRAME_BITS-2];
                  next_s.bit_i = s.bit_i + 5'h01;
                  next_s.st = SH_LOW;
               end
            end
         end
         default: next_s.st = SH_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sck = s.sck;
   assign mosi = s.mosi;
   assign done = s.done;
   assign rx = s.rx;

   // ==========================================================
   // Checks
   logic [7:0] run;
   // Phase length counter, held at zero between frames
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run <= '0;
      end else if (next_s.sck != s.sck || s.st == SH_IDLE) begin
         run <= 8'h00;
      end else begin
         run <= run + 8'h01;
      end
   end

   sck_phase_a: assert property (
      @(posedge clk) disable iff (rst)
      $changed(sck) |-> $past(run) == HALF_LAST)
      else $error("serial clock phase too short");
   mosi_stable_a: assert property (
      @(posedge clk) disable iff (rst)
      $rose(sck) |-> $stable(mosi) && $past(mosi, 2) == mosi)
      else $error("MOSI moved at the rising edge");
endmodule

// *** dv/isp_dev.sv ***
// ==========================================================
// Target device model seen from its serial programming pins
module isp_dev (
   input wire logic clk,
   input wire logic reset_pin,
   input wire logic sck,
   input wire logic mosi,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   import isp_pkg::*;
   int bad_echo = 0, busy_cyc = 8, busy = 0, viol = 0;
   int min_phase = 1000, ph = 0, cnt = 0;
   logic en = 1'b0, ok = 1'b0, drv = 1'b0, sck_q = 1'b0;
   logic [31:0] sr = 32'h0000_0000;
   logic [7:0] obuf = 8'h00;
   logic [15:0] flash [1024];
   logic [15:0] pbuf [64];
   logic [7:0] ee [256];
   logic [7:0] ebuf [4];
   logic [3:0] eld = 4'h0;

   // Blank arrays, one marked EEPROM byte
   initial begin
      foreach (flash[i]) flash[i] = 16'hFFFF;
      foreach (pbuf[i]) pbuf[i] = 16'hFFFF;
      foreach (ee[i]) ee[i] = 8'hFF;
      ee[8'h42] = 8'h77;
   end

   // Busy timer and shortest serial clock phase, in clock cycles
   always @(posedge clk) begin
      if (busy > 0) busy = busy - 1;
      if (sck !== sck_q && !reset_pin) begin
         if (ph < min_phase) min_phase = ph;
         ph = 1;
      end else ph = ph + 1;
      sck_q = sck;
   end

   // Reset high leaves programming mode
   always @(posedge reset_pin) begin
      en = 1'b0;
      cnt = 0;
   end

   // Rising edge: shift in MOSI and run a whole frame
   always @(posedge sck) begin
      if (!reset_pin) begin
         sr = {sr[30:0], mosi};
         cnt = cnt + 1;
         if (cnt == 8 && busy > 0 && sr[7:0] != INS_POLL)
            viol = viol + 1;
         if (cnt == 32) begin
            cnt = 0;
            run();
         end
      end
   end

   // Falling edge: load reply bytes and move MISO on
   always @(negedge sck) begin
      if (!reset_pin) begin
         if (cnt == 16) begin
            ok = bad_echo == 0 && sr[7:0] == ENABLE_KEY;
            obuf = sr[7:0];
            if (sr[15:8] == INS_ENABLE && bad_echo > 0) begin
               obuf = ~sr[7:0];
               bad_echo = bad_echo - 1;
            end
         end
         if (cnt == 24) obuf = reply(sr[23:0]);
         drv = obuf[7];
         obuf = {obuf[6:0], ~obuf[0]};
      end
   end
   assign miso = reset_pin ? ~drv : drv;

   // Reply byte of a frame from its first three bytes
   function automatic logic [7:0] reply(logic [23:0] f);
      if (!en) return 8'h3C;
      case (f[23:16])
         INS_RD_LO: return flash[f[9:0]][7:0];
         INS_RD_HI: return flash[f[9:0]][15:8];
         INS_RD_EE: return ee[f[7:0]];
         INS_POLL: return {7'h00, busy > 0};
         default: return 8'h3C;
      endcase
   endfunction

   // Carry out a received instruction
   task run;
      if (sr[31:24] != INS_ENABLE && !en) return;
      case (sr[31:24])
         INS_ENABLE: begin
            if (sr[23:16] == ENABLE_KEY) en = ok;
            else if (en && sr[23:16] == ERASE_KEY) begin
               foreach (flash[i]) flash[i] = 16'hFFFF;
               foreach (ee[i]) ee[i] = 8'hFF;
               busy = busy_cyc;
            end
         end
         INS_LD_LO: pbuf[sr[13:8]][7:0] = sr[7:0];
         INS_LD_HI: pbuf[sr[13:8]][15:8] = sr[7:0];
         INS_WR_PAGE: begin
            for (int i = 0; i < 64; i++) begin
               flash[{sr[17:14], i[5:0]}] = pbuf[i];
               pbuf[i] = 16'hFFFF;
            end
            busy = busy_cyc;
         end
         INS_LD_EE: begin
            ebuf[sr[9:8]] = sr[7:0];
            eld[sr[9:8]] = 1'b1;
         end
         INS_WR_EE_PAGE: begin
            for (int i = 0; i < 4; i++)
               if (eld[i]) ee[{sr[15:10], i[1:0]}] = ebuf[i];
            eld = 4'h0;
            busy = busy_cyc;
         end
         INS_WR_EE: begin
            ee[sr[15:8]] = sr[7:0];
            busy = busy_cyc;
         end
         default: ;
      endcase
   endtask
endmodule

// *** dv/tb.sv ***
// ==========================================================
// Programmer bench against the target model
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import isp_pkg::*;
   localparam int LIMIT = 95000;
   logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, poll_mode = 1'b0;
   logic cmd_ready, rsp_valid, rsp_error, err;
   logic isp_reset_pin, isp_sck, isp_mosi, isp_miso;
   isp_op_type cmd_op = OP_ENABLE;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_data = 8'h00, rsp_data, got;
   int n_fail = 0, num_checks = 0, cyc = 0;

   isp_prog #(.PWR_WAIT(20), .FLASH_WAIT(10), .EEPROM_WAIT(10)) u_isp_prog (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .poll_mode(poll_mode), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
      .rsp_data(rsp_data), .isp_reset_pin(isp_reset_pin),
      .isp_sck(isp_sck), .isp_mosi(isp_mosi), .isp_miso(isp_miso));
   isp_dev u_isp_dev (.clk(clk), .reset_pin(isp_reset_pin),
      .sck(isp_sck), .mosi(isp_mosi), .miso(isp_miso));

   always #2.5 clk = ~clk;

   // Cycle ceiling against a hang
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task chk_bit(logic g, logic e, string what);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask

   task chk_byte(logic [7:0] g, logic [7:0] e, string what);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s %h", $time, what, g);
      end
   endtask

   // One command: hold it until taken, then wait for its answer
   task cmd(isp_op_type op, logic [15:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      do @(negedge clk); while (cmd_ready !== 1'b1 && ++n < 100);
      chk_bit(cmd_ready, 1'b1, "command never taken");
      @(posedge clk);
      cmd_valid <= 1'b0;
      n = 0;
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 40000);
      chk_bit(rsp_valid, 1'b1, "command never answered");
      err = rsp_error;
      got = rsp_data;
   endtask

   task rdchk(isp_op_type op, logic [15:0] a, logic [7:0] e);
      cmd(op, a, 8'h00);
      chk_byte(got, e, "read data");
   endtask

   task t_power;
      @(negedge clk);
      chk_bit(isp_reset_pin, 1'b0, "reset pin");
      chk_bit(isp_sck, 1'b0, "sck idle");
      repeat (15) @(negedge clk);
      chk_bit(cmd_ready, 1'b0, "ready early");
      cmd(OP_RD_FLASH_LO, 16'h0000, 8'h00);
      chk_bit(err, 1'b1, "read before enable");
      $display("test power done");
   endtask

   task t_enable;
      u_isp_dev.bad_echo = 1;
      cmd(OP_ENABLE, 16'h0000, 8'h00);
      chk_bit(err, 1'b0, "enable retry");
      chk_bit(u_isp_dev.en, 1'b1, "target enabled");
      $display("test enable done");
   endtask

   task t_flash;
      @(posedge clk);
      poll_mode <= 1'b0;
      u_isp_dev.busy_cyc = 8;
      cmd(OP_LD_FLASH_LO, 16'h0145, 8'h34);
      cmd(OP_LD_FLASH_HI, 16'h0145, 8'h12);
      cmd(OP_LD_FLASH_HI, 16'h0145, 8'h99);
      chk_bit(err, 1'b1, "high twice");
      cmd(OP_WR_FLASH_PAGE, 16'h0140, 8'h00);
      chk_bit(err, 1'b0, "page write");
      rdchk(OP_RD_FLASH_LO, 16'h0145, 8'h34);
      rdchk(OP_RD_FLASH_HI, 16'h0145, 8'h12);
      rdchk(OP_RD_FLASH_LO, 16'h0146, 8'hFF);
      $display("test flash done");
   endtask

   task t_eeprom;
      @(posedge clk);
      poll_mode <= 1'b1;
      u_isp_dev.busy_cyc = 5000;
      cmd(OP_WR_EE_BYTE, 16'h0023, 8'h5A);
      chk_bit(err, 1'b0, "byte write");
      cmd(OP_LD_EE_PAGE, 16'h0041, 8'h11);
      cmd(OP_WR_EE_PAGE, 16'h0040, 8'h00);
      rdchk(OP_RD_EE, 16'h0041, 8'h11);
      rdchk(OP_RD_EE, 16'h0042, 8'h77);
      rdchk(OP_RD_EE, 16'h0023, 8'h5A);
      chk_bit(u_isp_dev.viol == 0, 1'b1, "access while busy");
      $display("test eeprom done");
   endtask

   task t_erase;
      @(posedge clk);
      poll_mode <= 1'b0;
      u_isp_dev.busy_cyc = 8;
      cmd(OP_ERASE, 16'h0000, 8'h00);
      cmd(OP_POLL, 16'h0000, 8'h00);
      chk_byte(got, 8'h00, "poll after erase wait");
      rdchk(OP_RD_EE, 16'h0023, 8'hFF);
      rdchk(OP_RD_FLASH_HI, 16'h0145, 8'hFF);
      chk_bit(u_isp_dev.viol == 0, 1'b1, "access while busy");
      $display("test erase done");
   endtask

   task t_end;
      cmd(OP_END, 16'h0000, 8'h00);
      chk_bit(isp_reset_pin, 1'b1, "reset released");
      cmd(OP_RD_EE, 16'h0023, 8'h00);
      chk_bit(err, 1'b1, "read after end");
      u_isp_dev.bad_echo = 4;
      cmd(OP_ENABLE, 16'h0000, 8'h00);
      chk_bit(err, 1'b1, "echo never seen");
      chk_bit(u_isp_dev.min_phase > 37, 1'b1, "sck phase");
      $display("test end done");
   endtask

   // Reset, then the scenarios in order
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_power;
      t_enable;
      t_flash;
      t_eeprom;
      t_erase;
      t_end;
      report_and_stop();
   end
endmodule
